// ---- src/sfch_spi_frame_handler.v ----
// serial command frame handler: decodes 32-bit frames into register reads
// and writes, checks length and parity, and returns status flags and data.
// assumes cs_n, sclk and si come from pins outside the sys_clk domain and
// that sclk is much slower than sys_clk; event inputs are sys_clk logic.
`timescale 1ns/1ps
`default_nettype none
`include "sfch_defines.vh"

// Summary of operation
// - msb low in frame means read
// - msb high in frame means write
// - six address bits follow the command bit
// - read ignores frame bits 24 to 1
// - write carries new data in bits 24..1
// - bit 0 carries parity both directions
// - read returns flags, register data, then parity
// - test register reads return their content
// - read of unmapped address returns zeros
// - write to non-writable address changes nothing
// - old content captured after bit 25, shifted out
// - valid write updates register at frame end
// - invalid write discards data, keeps content
// - test register write ignored, content returned
// - write to unmapped address returns zeros
// - every frame outputs flags mirrored from status
// - status read clears register at cs rise
// - reset sets the reset-event flag
// - non-32-bit frame sets frame error, interrupt low
// - no clock edges means no frame error
// - sample si on fall, drive so on rise
// - cs fall enables so, snapshots status
// - even input parity sets parity error flag
// - interrupt released at cs rise after status read
module sfch_spi_frame_handler (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire si_pin,
    output reg so_out,
    output reg so_oe,
    output reg int_n,
    input wire soft_reset,
    input wire ev_switch_change,
    input wire ev_temp_warn,
    input wire ev_temp_shutdown,
    input wire ev_other,
    input wire [23:0] switch_status,
    output wire [`SFCH_CFG_COUNT*24-1:0] cfg_flat,
    output reg [23:0] int_stat
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    reg [2:0] cs_sync;              // cs_n sync pair plus edge history
    reg [2:0] sclk_sync;            // sclk sync pair plus edge history
    reg [1:0] si_sync;              // si sync pair
    reg [31:0] rx_word;             // incoming frame shift register
    reg [31:0] tx_word;             // outgoing frame image
    reg [5:0] rx_cnt;               // falling edges seen, saturating
    reg [5:0] tx_cnt;               // rising edges seen, saturating
    reg [6:0] flag_snap;            // status flags caught at cs fall
    reg [23:0] cfg_mem [0:`SFCH_CFG_COUNT-1]; // writable configuration
    reg [23:0] next_int_stat;       // status after this cycle's events
    reg [23:0] old_data;            // addressed content, for the reply
    reg [1:0] old_kind;             // addressed register kind
    integer i;

    wire cs_low = ~cs_sync[1];                       // selected, synced
    wire cs_fall = cs_sync[2] & ~cs_sync[1];         // selection starts
    wire cs_rise = ~cs_sync[2] & cs_sync[1];         // selection ends
    wire sclk_fall = cs_low & sclk_sync[2] & ~sclk_sync[1];
    wire sclk_rise = cs_low & ~sclk_sync[2] & sclk_sync[1];
    // address as it completes: six bits in plus the seventh arriving now
    wire [5:0] rx_addr = {rx_word[4:0], si_sync[1]};
    // status flags in output order, from the live status register
    wire [6:0] flag_now = {int_stat[`SFCH_IS_POR], int_stat[`SFCH_IS_SPI_FAIL],
        int_stat[`SFCH_IS_PARITY_ERROR_FLAG], int_stat[`SFCH_IS_SSC], 1'b0,
        int_stat[`SFCH_IS_TW] | int_stat[`SFCH_IS_TSD], int_stat[`SFCH_IS_OTHER]};
    wire [5:0] fr_addr = rx_word[`SFCH_ADDR_MSB:`SFCH_ADDR_LSB];
    wire fr_write = rx_word[`SFCH_RW_POS];
    wire [1:0] fr_kind = reg_kind(fr_addr);

    // register kinds
    localparam [1:0] KIND_NONE = 2'd0;   // nothing mapped
    localparam [1:0] KIND_RO = 2'd1;     // read-only functional
    localparam [1:0] KIND_CFG = 2'd2;    // writable configuration
    localparam [1:0] KIND_TEST = 2'd3;   // test mode, never written

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // classify an address
    function [1:0] reg_kind;
        input [5:0] addr;
        begin
            if (addr == `SFCH_ADDR_ID || addr == `SFCH_ADDR_INT_STAT ||
                addr == `SFCH_ADDR_SW_STAT) begin
                reg_kind = KIND_RO;
            end else if (addr >= `SFCH_ADDR_CFG_BASE && addr <= `SFCH_ADDR_CFG_LAST) begin
                reg_kind = KIND_CFG;
            end else if (addr >= `SFCH_ADDR_TEST_BASE && addr <= `SFCH_ADDR_TEST_LAST) begin
                reg_kind = KIND_TEST;
            end else begin
                reg_kind = KIND_NONE;
            end
        end
    endfunction

    // index into the configuration array
    function [2:0] cfg_index;
        input [5:0] addr;
        reg [5:0] diff;
        begin
            diff = addr - `SFCH_ADDR_CFG_BASE;
            cfg_index = diff[2:0];
        end
    endfunction

    // odd parity bit that makes the word's count of ones odd
    function odd_par;
        input [30:0] bits;
        begin
            odd_par = ~(^bits);
        end
    endfunction

    // ------------------------------------------------------------------
    // addressed content lookup
    // ------------------------------------------------------------------
    // test registers give their fixed content like any other read
    always @* begin
        old_kind = reg_kind(rx_addr);
        case (old_kind)
            KIND_RO: begin
                if (rx_addr == `SFCH_ADDR_ID) begin
                    old_data = `SFCH_ID_VALUE;     // arbitrary identity value
                end else if (rx_addr == `SFCH_ADDR_INT_STAT) begin
                    old_data = int_stat;
                end else begin
                    old_data = switch_status;
                end
            end
            KIND_CFG: old_data = cfg_mem[cfg_index(rx_addr)];
            KIND_TEST: old_data = `SFCH_TEST_RST;
            default: old_data = 24'h000000;
        endcase
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // two flops per pin; the third cs and sclk stage only feeds edge finding
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync <= 3'h7;
            sclk_sync <= 3'h0;
            si_sync <= 2'h0;
        end else if (clk_en) begin
            cs_sync <= {cs_sync[1:0], cs_n_pin};
            sclk_sync <= {sclk_sync[1:0], sclk_pin};
            si_sync <= {si_sync[0], si_pin};
        end
    end

    // ------------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------------
    // si shifts in msb first on each falling sclk edge
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_word <= 32'h00000000;
            rx_cnt <= 6'h00;
        end else if (clk_en) begin
            if (cs_fall) begin
                rx_cnt <= 6'h00;
            end else if (sclk_fall) begin
                rx_word <= {rx_word[30:0], si_sync[1]};
                if (rx_cnt != `SFCH_CNT_MAX) begin
                    rx_cnt <= rx_cnt + 6'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------------
    // flags go out first, data is patched in once the address is known
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_word <= 32'h00000000;
            tx_cnt <= 6'h00;
            flag_snap <= 7'h00;
            so_out <= 1'b0;
            so_oe <= 1'b0;
        end else if (clk_en) begin
            so_oe <= cs_low;
            if (cs_fall) begin
                // status is snapshotted and mirrored into the flag field
                flag_snap <= flag_now;
                tx_word <= {flag_now, 25'h0000000};
                tx_cnt <= 6'h00;
                so_out <= 1'b1;                                   // idle high
            end else if (sclk_fall && rx_cnt == `SFCH_HDR_BITS - 6'h01) begin
                // seventh bit just arrived: address decoded, old content caught
                if (old_kind == KIND_NONE) begin
                    tx_word[24:0] <= 25'h0000000;
                end else begin
                    tx_word[`SFCH_DATA_MSB:`SFCH_DATA_LSB] <= old_data;
                    tx_word[`SFCH_PAR_POS] <= odd_par({flag_snap, old_data});
                end
            end else if (sclk_rise) begin
                // next bit on each rising edge, zeros past the frame
                if (tx_cnt < `SFCH_FRAME_BITS) begin
                    so_out <= tx_word[5'd31 - tx_cnt[4:0]];
                    tx_cnt <= tx_cnt + 6'h01;
                end else begin
                    so_out <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt status next value
    // ------------------------------------------------------------------
    // frame end checks, clear on status read; new events win over the clear
    always @* begin
        next_int_stat = int_stat;
        if (cs_rise && rx_cnt != 6'h00) begin
            if (rx_cnt != `SFCH_FRAME_BITS) begin
                next_int_stat[`SFCH_IS_SPI_FAIL] = 1'b1;
            end else if (!(^rx_word)) begin
                next_int_stat[`SFCH_IS_PARITY_ERROR_FLAG] = 1'b1;
            end else if (!fr_write && fr_addr == `SFCH_ADDR_INT_STAT) begin
                next_int_stat = 24'h000000;
            end
        end
        if (soft_reset) begin
            next_int_stat[`SFCH_IS_POR] = 1'b1;
        end
        if (ev_switch_change) begin
            next_int_stat[`SFCH_IS_SSC] = 1'b1;
        end
        if (ev_temp_warn) begin
            next_int_stat[`SFCH_IS_TW] = 1'b1;
        end
        if (ev_temp_shutdown) begin
            next_int_stat[`SFCH_IS_TSD] = 1'b1;
        end
        if (ev_other) begin
            next_int_stat[`SFCH_IS_OTHER] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and interrupt pin
    // ------------------------------------------------------------------
    // the pin is low while any status bit stands, so a status read releases it
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat <= `SFCH_INT_STAT_RST;
            int_n <= 1'b0;
        end else if (clk_en) begin
            int_stat <= next_int_stat;
            int_n <= ~(|next_int_stat);
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // written only at cs rise by a whole, parity-clean write to a cfg address, or cleared by soft_reset
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `SFCH_CFG_COUNT; i = i + 1) begin
                cfg_mem[i] <= `SFCH_CFG_RST;
            end
        end else if (clk_en) begin
            if (soft_reset) begin
                for (i = 0; i < `SFCH_CFG_COUNT; i = i + 1) begin
                    cfg_mem[i] <= `SFCH_CFG_RST;
                end
            end else if (cs_rise && rx_cnt == `SFCH_FRAME_BITS && (^rx_word) &&
                fr_write && fr_kind == KIND_CFG) begin
                cfg_mem[cfg_index(fr_addr)] <=
                    rx_word[`SFCH_DATA_MSB:`SFCH_DATA_LSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------------
    // register i sits at bits 24*i+23 .. 24*i; read frames never touch them
    genvar g;
    generate
        for (g = 0; g < `SFCH_CFG_COUNT; g = g + 1) begin : cfg_out
            assign cfg_flat[g*24 +: 24] = cfg_mem[g];
        end
    endgenerate

endmodule // sfch_spi_frame_handler
`default_nettype wire

// ---- src/sfch_defines.vh ----
// constants for the serial command frame handler: frame layout, address map,
// interrupt status bit positions and reset values.
// assumes a 32-bit frame, msb first, and a 24-bit register width.
`ifndef SFCH_DEFINES_VH
`define SFCH_DEFINES_VH

// ------------------------------------------------------------------
// frame layout
// ------------------------------------------------------------------
`define SFCH_FRAME_BITS 6'd32
`define SFCH_CNT_MAX 6'd33
`define SFCH_HDR_BITS 6'd7
`define SFCH_RW_POS 31
`define SFCH_ADDR_MSB 30
`define SFCH_ADDR_LSB 25
`define SFCH_DATA_MSB 24
`define SFCH_DATA_LSB 1
`define SFCH_PAR_POS 0

// ------------------------------------------------------------------
// address map
// ------------------------------------------------------------------
`define SFCH_ADDR_ID 6'h01
`define SFCH_ADDR_INT_STAT 6'h04
`define SFCH_ADDR_SW_STAT 6'h05
`define SFCH_ADDR_CFG_BASE 6'h1a
`define SFCH_CFG_COUNT 8
`define SFCH_ADDR_CFG_LAST 6'h21
`define SFCH_ADDR_TEST_BASE 6'h30
`define SFCH_ADDR_TEST_LAST 6'h33

// ------------------------------------------------------------------
// interrupt status bit positions
// ------------------------------------------------------------------
`define SFCH_IS_POR 0
`define SFCH_IS_SPI_FAIL 1
`define SFCH_IS_PARITY_ERROR_FLAG 2
`define SFCH_IS_SSC 3
`define SFCH_IS_TW 4
`define SFCH_IS_TSD 5
`define SFCH_IS_OTHER 6

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define SFCH_INT_STAT_RST 24'h000001
`define SFCH_CFG_RST 24'h000000
`define SFCH_TEST_RST 24'h5a5a00
`define SFCH_ID_VALUE 24'h00a001 // arbitrary identity value

`endif

// ---- testbench/sfch_frame_checker_sva.sv ----
// assertion checker for the serial frame handler, bound to its top module.
// assumes sys_clk is the only clock and rst_n its active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sfch_frame_checker (
    input wire sys_clk,
    input wire rst_n,
    input wire cs_n_pin,
    input wire so_out,
    input wire so_oe,
    input wire int_n,
    input wire soft_reset,
    input wire ev_switch_change,
    input wire ev_temp_warn,
    input wire ev_temp_shutdown,
    input wire ev_other,
    input wire [191:0] cfg_flat,
    input wire [23:0] int_stat
);
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    chk_int_pin: assert property (int_n == (int_stat == 24'h0))
        else $error("interrupt pin disagrees with status");
    chk_oe_on: assert property ($fell(cs_n_pin) |-> ##[1:6] (so_oe && so_out))
        else $error("output not driven high after select");
    chk_oe_off: assert property ($rose(cs_n_pin) |-> ##[1:6] !so_oe)
        else $error("output still driven after deselect");
    chk_ev_switch: assert property (ev_switch_change |=> int_stat[3])
        else $error("switch change not recorded");
    chk_ev_temp: assert property (ev_temp_warn && ev_temp_shutdown |=> &int_stat[5:4])
        else $error("temperature event not recorded");
    chk_ev_other: assert property (ev_other |=> int_stat[6])
        else $error("other event not recorded");
    chk_soft_por: assert property (soft_reset |=> int_stat[0] && cfg_flat == 192'h0)
        else $error("soft reset did not set reset flag");
    chk_cfg_quiet: assert property (!$stable(cfg_flat) |-> cs_n_pin || $past(soft_reset))
        else $error("config changed inside a frame");
    chk_stat_clear: assert property ((($past(int_stat) & ~int_stat) != 24'h0) |-> cs_n_pin)
        else $error("status cleared while selected");
endmodule // sfch_frame_checker
bind sfch_spi_frame_handler sfch_frame_checker sfch_frame_checker_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .so_out(so_out),
    .so_oe(so_oe), .int_n(int_n), .soft_reset(soft_reset),
    .ev_switch_change(ev_switch_change), .ev_temp_warn(ev_temp_warn),
    .ev_temp_shutdown(ev_temp_shutdown), .ev_other(ev_other),
    .cfg_flat(cfg_flat), .int_stat(int_stat)
);
`default_nettype wire

// ---- testbench/sfch_commander.sv ----
// serial commander model: drives select, link clock and data, reads so.
// assumes the handler's sys_clk is far faster than the 125 ns link clock.
`timescale 1ns/1ps
`default_nettype none
module sfch_commander (
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so
);
    logic [31:0] rx; // word seen on so
    event done; // fires when a whole word is in
    initial begin
        cs_n = 1'b1; // idle deselected
        sclk = 1'b0; // clock stands still outside frames
        si = 1'b1;
    end
    // one frame of n bits, msb first; n of 32 is a legal word
    task automatic xfer(input logic [31:0] w, input int n);
        rx = 32'h0;
        #0.25; // shifts the frame 0.25 ns; link edges miss sys_clk edges if the task starts on a whole or half ns
        cs_n = 1'b0;
        for (int k = 31; k > 31 - n; k--) begin
            #42.5 si = w[k];
            #20 sclk = 1'b1;
            #62.5 sclk = 1'b0;
            rx[k] = so; // sampled on fall
        end
        #62.5 cs_n = 1'b1;
        si = ~si; // released line shows no stale value
        if (n == 32)
            ->done;
        #60;
    endtask
endmodule // sfch_commander
`default_nettype wire

// ---- testbench/spi_frame_command_handler_bench.sv ----
// self-checking bench for the serial frame handler.
// assumes the defines header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sfch_defines.vh"
module spi_frame_command_handler_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_reset = 1'b0;
    logic [3:0] ev = 4'h0; // switch, warn, shutdown, other
    logic [23:0] sw = 24'h0;
    wire cs_n_pin, sclk_pin, si_pin, so_out, so_oe, int_n;
    wire [191:0] cfg_flat;
    wire [23:0] int_stat;
    logic [23:0] m_is = 24'h1; // expected status
    logic [23:0] m_cfg [8]; // expected config
    logic [31:0] q [$]; // expected replies
    logic [31:0] e;
    int n_fail = 0;
    int total_checks = 0;
    always #2 sys_clk = ~sys_clk;
    sfch_spi_frame_handler sfch_spi_frame_handler_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(1'b1), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .si_pin(si_pin),
        .so_out(so_out), .so_oe(so_oe), .int_n(int_n), .soft_reset(soft_reset),
        .ev_switch_change(ev[0]), .ev_temp_warn(ev[1]), .ev_temp_shutdown(ev[2]),
        .ev_other(ev[3]), .switch_status(sw), .cfg_flat(cfg_flat), .int_stat(int_stat));
    sfch_commander sfch_commander_i (.cs_n(cs_n_pin), .sclk(sclk_pin), .si(si_pin), .so(so_out));
    function automatic logic [31:0] cmd(logic rw, logic [5:0] a, logic [23:0] d);
        cmd = {rw, a, d, 1'b0};
        cmd[0] = ~^cmd[31:1]; // odd parity
    endfunction
    function automatic logic [31:0] reply(logic [5:0] a);
        logic [23:0] d;
        logic ok;
        ok = 1'b1;
        d = 24'h0;
        if (a == `SFCH_ADDR_ID) d = `SFCH_ID_VALUE;
        else if (a == `SFCH_ADDR_INT_STAT) d = m_is;
        else if (a == `SFCH_ADDR_SW_STAT) d = sw;
        else if (a >= `SFCH_ADDR_CFG_BASE && a <= `SFCH_ADDR_CFG_LAST) d = m_cfg[a - 6'h1a];
        else if (a >= `SFCH_ADDR_TEST_BASE && a <= `SFCH_ADDR_TEST_LAST) d = `SFCH_TEST_RST;
        else ok = 1'b0;
        reply = {m_is[0], m_is[1], m_is[2], m_is[3], 1'b0, m_is[4] | m_is[5], m_is[6], d, 1'b0};
        reply[0] = ok & ~^reply[31:1];
    endfunction
    task automatic chk_state(logic [23:0] g, logic [23:0] x);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] %0t state got %h exp %h", $time, g, x);
        end
    endtask
    task automatic state_check;
        chk_state(int_stat, m_is);
        chk_state({23'h0, int_n}, {23'h0, m_is == 24'h0});
        for (int i = 0; i < 8; i++) chk_state(cfg_flat[24*i +: 24], m_cfg[i]);
    endtask
    // one frame; bad flips the parity bit
    task automatic run(logic rw, logic [5:0] a, logic [23:0] d, int n, logic bad);
        if (n == 32) q.push_back(reply(a));
        sfch_commander_i.xfer(cmd(rw, a, d) ^ {31'h0, bad}, n);
        if (n != 32 && n != 0) m_is[1] = 1'b1;
        else if (bad) m_is[2] = 1'b1;
        else if (n == 32) begin
            if (!rw && a == `SFCH_ADDR_INT_STAT) m_is = 24'h0;
            if (rw && a >= 6'h1a && a <= 6'h21) m_cfg[a - 6'h1a] = d;
        end
        state_check();
    endtask
    task automatic pulse(logic [3:0] v, logic sr);
        @(posedge sys_clk);
        ev <= v;
        soft_reset <= sr;
        @(posedge sys_clk);
        ev <= 4'h0;
        soft_reset <= 1'b0;
        m_is[6:3] = m_is[6:3] | v;
        if (sr) begin
            m_is[0] = 1'b1;
            for (int i = 0; i < 8; i++) m_cfg[i] = 24'h0;
        end
        repeat (2) @(posedge sys_clk);
        #1 state_check();
    endtask
    task automatic end_sim;
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_frame(logic [31:0] g, logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] %0t frame got %h exp %h", $time, g, x);
        end
    endtask
    // reply watcher
    initial forever begin
        @(sfch_commander_i.done);
        e = q.pop_front();
        chk_frame(sfch_commander_i.rx, e);
    end
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hcb983a23));
        for (int i = 0; i < 8; i++) m_cfg[i] = 24'h0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 state_check();
        run(0, 6'h04, 24'h0, 32, 0);
        for (int i = 0; i < 8; i++) run(1, 6'(26 + i), 24'($urandom), 32, 0);
        for (int i = 0; i < 8; i++) run(0, 6'(26 + i), 24'($urandom), 32, 0);
        run(1, 6'h1b, 24'($urandom), 32, 1);
        run(1, 6'h1c, 24'($urandom), 20, 0);
        run(0, 6'h04, 24'h0, 32, 0);
        run(0, 6'h00, 24'h0, 0, 0);
        @(posedge sys_clk);
        sw <= 24'($urandom);
        run(0, 6'h01, 24'h0, 32, 0);
        run(0, 6'h05, 24'h0, 32, 0);
        run(0, 6'h30, 24'h0, 32, 0);
        run(1, 6'h33, 24'h123456, 32, 0);
        run(0, 6'h3f, 24'h0, 32, 0);
        run(1, 6'h02, 24'hffffff, 32, 0);
        pulse(4'hf, 1'b0);
        run(1, 6'h21, 24'h00ff00, 32, 0);
        run(0, 6'h04, 24'h0, 32, 0);
        pulse(4'h0, 1'b1);
        run(0, 6'h04, 24'h0, 32, 0);
        end_sim();
    end
endmodule // spi_frame_command_handler_bench
`default_nettype wire
